// [core/cesr_top.sv]
// Event latch, live condition and gate registers behind a two-wire port
// Notes on behaviour
// - Event latch bit 0 flags a power good event; reads zero once cleared.
// - Event latch bit 7 flags a thermal trip event; zero after clearing.
// - Bits 7..5 thermal trip/warn/prewarn, 4..3 zero, 2..0 input low/oc/pg.
// - Live bit 6 is one while junction is over the thermal warning limit.
// - Live condition at address one, read-only, resets to zero, same order.
// - Reading event latch returns it then clears; RO ignores writes, RW stores.
// - Gate bit per source: zero enables, one masks; all reset to one.
module cesr_top #(
    parameter logic [6:0] CHIP_ADDR = cesr_pkg::DEFAULT_CHIP_ADDR
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic scl,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic power_good_live,
    input  wire logic overcurrent_live,
    input  wire logic input_low_live,
    input  wire logic thermal_prewarn_live,
    input  wire logic thermal_warn_live,
    input  wire logic thermal_trip_live,
    output logic [7:0] source_gate
);

    cesr_pkg::cesr_state_t s_reg;
    cesr_pkg::cesr_state_t s_next;

    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic [7:0] live_now;
    logic [7:0] live_edge;
    logic       clr_events;
    logic       wr_stb;
    logic [7:0] rd_byte;

    function automatic logic [7:0] read_reg(
        input logic [7:0] addr,
        input cesr_pkg::cesr_state_t st
    );
        if (addr == cesr_pkg::OFS_EVENT_LATCH) begin
            read_reg = st.events;
        end else if (addr == cesr_pkg::OFS_LIVE_COND) begin
            read_reg = st.live;
        end else if (addr == cesr_pkg::OFS_SOURCE_GATE) begin
            read_reg = st.gate;
        end else begin
            read_reg = 8'h00;
        end
    endfunction : read_reg

    // Pins are synchronous to core_clk, so one sample stage is enough
    assign scl_rise  = scl & ~s_reg.scl_q;
    assign scl_fall  = ~scl & s_reg.scl_q;
    assign bus_start = s_reg.scl_q & scl & s_reg.sda_q & ~sda_in;
    assign bus_stop  = s_reg.scl_q & scl & ~s_reg.sda_q & sda_in;

    always_comb begin
        live_now = 8'h00;
        live_now[cesr_pkg::BIT_POWER_GOOD]      = power_good_live;
        live_now[cesr_pkg::BIT_OVERCURRENT]     = overcurrent_live;
        live_now[cesr_pkg::BIT_INPUT_LOW]       = input_low_live;
        live_now[cesr_pkg::BIT_THERMAL_PREWARN] = thermal_prewarn_live;
        live_now[cesr_pkg::BIT_THERMAL_WARN]    = thermal_warn_live;
        live_now[cesr_pkg::BIT_THERMAL_TRIP]    = thermal_trip_live;
    end

    assign live_edge = live_now ^ s_reg.live;
    assign rd_byte   = read_reg(s_reg.ptr, s_reg);

    always_comb begin
        s_next     = s_reg;
        clr_events = 1'b0;
        wr_stb     = 1'b0;
        s_next.scl_q = scl;
        s_next.sda_q = sda_in;
        s_next.live  = live_now & ~cesr_pkg::SPARE_MASK;

        if (bus_start) begin
            s_next.fsm     = cesr_pkg::CESR_ADDR;
            s_next.bit_cnt = 4'h0;
            s_next.sda_oe  = 1'b0;
        end else if (bus_stop) begin
            s_next.fsm    = cesr_pkg::CESR_IDLE;
            s_next.sda_oe = 1'b0;
        end else begin
            case (s_reg.fsm)
                cesr_pkg::CESR_ADDR, cesr_pkg::CESR_REG,
                cesr_pkg::CESR_WDATA: begin
                    if (scl_rise) begin
                        s_next.shift   = {s_reg.shift[6:0], sda_in};
                        s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                    end else if (scl_fall &&
                        s_reg.bit_cnt == cesr_pkg::BITS_PER_BYTE) begin
                        s_next.bit_cnt = 4'h0;
                        s_next.sda_oe  = 1'b1;
                        if (s_reg.fsm == cesr_pkg::CESR_ADDR) begin
                            if (s_reg.shift[7:1] == CHIP_ADDR) begin
                                s_next.rw  = s_reg.shift[0];
                                s_next.fsm = cesr_pkg::CESR_ADDR_ACK;
                            end else begin
                                // Not our address: stay off the bus
                                s_next.sda_oe = 1'b0;
                                s_next.fsm    = cesr_pkg::CESR_IDLE;
                            end
                        end else if (s_reg.fsm == cesr_pkg::CESR_REG) begin
                            s_next.ptr = s_reg.shift;
                            s_next.fsm = cesr_pkg::CESR_REG_ACK;
                        end else begin
                            wr_stb     = 1'b1;
                            s_next.ptr = s_reg.ptr + 8'h01;
                            s_next.fsm = cesr_pkg::CESR_WDATA_ACK;
                        end
                    end
                end
                cesr_pkg::CESR_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (s_reg.rw) begin
                            s_next.fsm = cesr_pkg::CESR_TX_LOAD;
                            s_next.sda_oe = 1'b0;
                        end else begin
                            s_next.sda_oe = 1'b0;
                            s_next.fsm    = cesr_pkg::CESR_REG;
                        end
                    end
                end
                cesr_pkg::CESR_REG_ACK, cesr_pkg::CESR_WDATA_ACK: begin
                    if (scl_fall) begin
                        s_next.sda_oe = 1'b0;
                        s_next.fsm    = cesr_pkg::CESR_WDATA;
                    end
                end
                cesr_pkg::CESR_TX_LOAD: begin
                    // Byte is captured here, so a read clears what it returned
                    s_next.shift   = rd_byte;
                    s_next.sda_oe  = ~rd_byte[7];
                    s_next.bit_cnt = 4'h0;
                    s_next.ptr     = s_reg.ptr + 8'h01;
                    s_next.fsm     = cesr_pkg::CESR_TX;
                    clr_events = s_reg.ptr == cesr_pkg::OFS_EVENT_LATCH;
                end
                cesr_pkg::CESR_TX: begin
                    if (scl_rise) begin
                        s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (s_reg.bit_cnt == cesr_pkg::BITS_PER_BYTE) begin
                            s_next.sda_oe = 1'b0;
                            s_next.fsm    = cesr_pkg::CESR_TX_ACK;
                        end else begin
                            s_next.shift  = {s_reg.shift[6:0], 1'b0};
                            s_next.sda_oe = ~s_reg.shift[6];
                        end
                    end
                end
                cesr_pkg::CESR_TX_ACK: begin
                    if (scl_rise) begin
                        // Master nack ends the burst
                        s_next.fsm = sda_in ? cesr_pkg::CESR_IDLE
                                            : cesr_pkg::CESR_TX_ACK;
                        s_next.rw  = ~sda_in;
                    end else if (scl_fall && s_reg.rw) begin
                        s_next.fsm = cesr_pkg::CESR_TX_LOAD;
                    end
                end
                default: begin
                    s_next.sda_oe = 1'b0;
                end
            endcase
        end

        // Only the gate is writable; latch and live ignore writes
        if (wr_stb && s_reg.ptr == cesr_pkg::OFS_SOURCE_GATE) begin
            s_next.gate = s_reg.shift;
        end

        // New edge wins over a read clear in the same cycle
        s_next.events = ((clr_events ? 8'h00 : s_reg.events)
                         | live_edge) & ~cesr_pkg::SPARE_MASK;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_reg         <= '0;
            s_reg.fsm     <= cesr_pkg::CESR_IDLE;
            s_reg.scl_q   <= 1'b1;
            s_reg.sda_q   <= 1'b1;
            s_reg.live    <= cesr_pkg::RST_LIVE_COND;
            s_reg.events  <= cesr_pkg::RST_EVENT_LATCH;
            s_reg.gate    <= cesr_pkg::RST_SOURCE_GATE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sda_out     = 1'b0;
    assign sda_oe      = s_reg.sda_oe;
    assign source_gate = s_reg.gate;

    chk_pg_event_set: assert property (@(posedge core_clk)
        disable iff (rst)
        (power_good_live != s_reg.live[0]) |=> s_reg.events[0])
        else $error("power good edge did not set flag");

    chk_trip_event_set: assert property (@(posedge core_clk)
        disable iff (rst)
        (thermal_trip_live != s_reg.live[7]) |=> s_reg.events[7])
        else $error("thermal trip edge did not set flag");

    chk_spare_bits_zero: assert property (@(posedge core_clk)
        disable iff (rst)
        (s_reg.events[4:3] == 2'b00) && (s_reg.live[4:3] == 2'b00))
        else $error("spare bits not zero");

    chk_warn_live_follow: assert property (@(posedge core_clk)
        disable iff (rst)
        ##1 s_reg.live[6] == $past(thermal_warn_live))
        else $error("thermal warn live bit wrong");

    chk_low_live_follow: assert property (@(posedge core_clk)
        disable iff (rst)
        input_low_live [*2] |-> s_reg.live[2])
        else $error("input low live bit wrong");

    chk_live_no_write: assert property (@(posedge core_clk)
        disable iff (rst)
        (wr_stb && s_reg.ptr == cesr_pkg::OFS_LIVE_COND && live_edge == 8'h00)
        |=> s_reg.live == $past(s_reg.live))
        else $error("live register changed by write");

    chk_read_clears: assert property (@(posedge core_clk)
        disable iff (rst)
        (clr_events && live_edge == 8'h00) |=> s_reg.events == 8'h00)
        else $error("event latch not cleared by read");

    chk_gate_write: assert property (@(posedge core_clk)
        disable iff (rst)
        (wr_stb && s_reg.ptr == cesr_pkg::OFS_SOURCE_GATE)
        |=> source_gate == $past(s_reg.shift))
        else $error("gate write not stored");

    chk_gate_hold: assert property (@(posedge core_clk)
        disable iff (rst)
        !wr_stb |=> $stable(source_gate))
        else $error("gate changed without write");

    chk_both_edges: assert property (@(posedge core_clk)
        disable iff (rst)
        (live_edge != 8'h00)
        |=> (s_reg.events & $past(live_edge)) == $past(live_edge))
        else $error("live edge lost");

endmodule : cesr_top

// [inc/cesr_pkg.sv]
// Constants and types for the converter event status registers
package cesr_pkg;

    localparam logic [7:0] OFS_EVENT_LATCH  = 8'h00;
    localparam logic [7:0] OFS_LIVE_COND    = 8'h01;
    localparam logic [7:0] OFS_SOURCE_GATE  = 8'h02;

    localparam logic [7:0] RST_EVENT_LATCH  = 8'h00;
    localparam logic [7:0] RST_LIVE_COND    = 8'h00;
    localparam logic [7:0] RST_SOURCE_GATE  = 8'hff;

    localparam int BIT_POWER_GOOD     = 0;
    localparam int BIT_OVERCURRENT    = 1;
    localparam int BIT_INPUT_LOW      = 2;
    localparam int BIT_THERMAL_PREWARN = 5;
    localparam int BIT_THERMAL_WARN   = 6;
    localparam int BIT_THERMAL_TRIP   = 7;
    localparam logic [7:0] SPARE_MASK = 8'h18;

    // Default seven-bit bus address of the register port
    localparam logic [6:0] DEFAULT_CHIP_ADDR = 7'h1c;
    localparam logic [3:0] BITS_PER_BYTE     = 4'h8;

    typedef enum logic [3:0] {
        CESR_IDLE,
        CESR_ADDR,
        CESR_ADDR_ACK,
        CESR_REG,
        CESR_REG_ACK,
        CESR_WDATA,
        CESR_WDATA_ACK,
        CESR_TX,
        CESR_TX_ACK,
        CESR_TX_LOAD
    } cesr_fsm_t;

    typedef struct packed {
        logic       scl_q;
        logic       sda_q;
        cesr_fsm_t  fsm;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic       rw;
        logic       sda_oe;
        logic [7:0] live;
        logic [7:0] events;
        logic [7:0] gate;
    } cesr_state_t;

endpackage : cesr_pkg

// [verification/cesr_top_tb.sv]
// Self-checking bench for the event latch, live and gate registers
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("[ERR] %0t got %0h exp %0h", $time, got, exp); \
    end \
end

module cesr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] ADDR_W = {cesr_pkg::DEFAULT_CHIP_ADDR, 1'b0};

    logic       core_clk;
    logic       rst;
    logic       scl;
    logic       m_sda;
    logic       sda_out;
    logic       sda_oe;
    logic [5:0] live;
    logic [7:0] source_gate;
    logic [7:0] d;
    logic [7:0] e;
    logic       a_bit;
    wire logic  sda_line;
    int         mismatches;
    int         total_checks;

    // Open-drain data line with a pull-up; device level only when enabled
    assign sda_line = m_sda & (sda_oe ? sda_out : 1'b1);

    // Source index to its bit in the latch and live registers
    function automatic int pos_of(input int i);
        case (i)
            0: pos_of = cesr_pkg::BIT_POWER_GOOD;
            1: pos_of = cesr_pkg::BIT_OVERCURRENT;
            2: pos_of = cesr_pkg::BIT_INPUT_LOW;
            3: pos_of = cesr_pkg::BIT_THERMAL_PREWARN;
            4: pos_of = cesr_pkg::BIT_THERMAL_WARN;
            default: pos_of = cesr_pkg::BIT_THERMAL_TRIP;
        endcase
    endfunction : pos_of

    cesr_top dut (
        .core_clk             (core_clk),
        .rst                  (rst),
        .scl                  (scl),
        .sda_in               (sda_line),
        .sda_out              (sda_out),
        .sda_oe               (sda_oe),
        .power_good_live      (live[0]),
        .overcurrent_live     (live[1]),
        .input_low_live       (live[2]),
        .thermal_prewarn_live (live[3]),
        .thermal_warn_live    (live[4]),
        .thermal_trip_live    (live[5]),
        .source_gate          (source_gate)
    );

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // One bus phase; four cycles keeps margin over the three-cycle minimum
    task automatic ph(input logic s, input logic v);
        scl   <= s;
        m_sda <= v;
        repeat (4) @(posedge core_clk);
    endtask : ph

    task automatic start_c;
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
        ph(1'b0, 1'b0);
    endtask : start_c

    task automatic stop_c;
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask : stop_c

    // Data moves only while clock is low, hence three phases per bit
    task automatic put(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            ph(1'b0, b[i]);
            ph(1'b1, b[i]);
            ph(1'b0, b[i]);
        end
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ack = ~sda_line;
        ph(1'b0, 1'b1);
    endtask : put

    task automatic get(output logic [7:0] b, input logic nack);
        for (int i = 7; i >= 0; i--) begin
            ph(1'b0, 1'b1);
            ph(1'b1, 1'b1);
            b[i] = sda_line;
        end
        ph(1'b0, 1'b1);
        ph(1'b0, nack);
        ph(1'b1, nack);
        ph(1'b0, nack);
    endtask : get

    task automatic wr(input logic [7:0] r, input logic [7:0] v);
        logic a;
        start_c();
        put(ADDR_W, a);
        `CHK(a, 1'b1)
        put(r, a);
        `CHK(a, 1'b1)
        put(v, a);
        `CHK(a, 1'b1)
        stop_c();
    endtask : wr

    // Pointer-setting write, then a one-byte read ended by a nack
    task automatic rd(input logic [7:0] r, output logic [7:0] v);
        logic a;
        start_c();
        put(ADDR_W, a);
        `CHK(a, 1'b1)
        put(r, a);
        `CHK(a, 1'b1)
        stop_c();
        start_c();
        put(ADDR_W | 8'h01, a);
        `CHK(a, 1'b1)
        get(v, 1'b1);
        stop_c();
    endtask : rd

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        mismatches++;
        end_of_test();
    end

    initial begin
        rst          = 1'b1;
        scl          = 1'b1;
        m_sda        = 1'b1;
        live         = 6'h00;
        mismatches   = 0;
        total_checks = 0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        rd(cesr_pkg::OFS_EVENT_LATCH, d);
        `CHK(d, cesr_pkg::RST_EVENT_LATCH)
        rd(cesr_pkg::OFS_LIVE_COND, d);
        `CHK(d, cesr_pkg::RST_LIVE_COND)
        `CHK(source_gate, cesr_pkg::RST_SOURCE_GATE)
        rd(cesr_pkg::OFS_SOURCE_GATE, d);
        `CHK(d, cesr_pkg::RST_SOURCE_GATE)
        wr(cesr_pkg::OFS_SOURCE_GATE, 8'h5a);
        `CHK(source_gate, 8'h5a)
        rd(cesr_pkg::OFS_SOURCE_GATE, d);
        `CHK(d, 8'h5a)
        wr(cesr_pkg::OFS_LIVE_COND, 8'hff);
        rd(cesr_pkg::OFS_LIVE_COND, d);
        `CHK(d, 8'h00)
        // Pointer now sits on the gate; master ack carries on to 0x03
        start_c();
        put(ADDR_W | 8'h01, a_bit);
        `CHK(a_bit, 1'b1)
        get(d, 1'b0);
        `CHK(d, 8'h5a)
        get(d, 1'b1);
        `CHK(d, 8'h00)
        stop_c();
        // Foreign address: no ack, port stays idle
        start_c();
        put(8'h50, a_bit);
        `CHK(a_bit, 1'b0)
        stop_c();
        wr(cesr_pkg::OFS_EVENT_LATCH, 8'hff);
        rd(cesr_pkg::OFS_EVENT_LATCH, d);
        `CHK(d, 8'h00)
        rd(8'h10, d);
        `CHK(d, 8'h00)
        // Each source alone: exact values also prove spares stay zero
        for (int i = 0; i < 6; i++) begin
            e = 8'h01 << pos_of(i);
            live[i] <= 1'b1;
            repeat (4) @(posedge core_clk);
            rd(cesr_pkg::OFS_LIVE_COND, d);
            `CHK(d, e)
            rd(cesr_pkg::OFS_EVENT_LATCH, d);
            `CHK(d, e)
            rd(cesr_pkg::OFS_EVENT_LATCH, d);
            `CHK(d, 8'h00)
            live[i] <= 1'b0;
            repeat (4) @(posedge core_clk);
            rd(cesr_pkg::OFS_LIVE_COND, d);
            `CHK(d, 8'h00)
            rd(cesr_pkg::OFS_EVENT_LATCH, d);
            `CHK(d, e)
        end
        end_of_test();
    end
endmodule : cesr_top_tb
